// ### wdr_consts.svh
`ifndef WDR_CONSTS_SVH
`define WDR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define WDR_OFS_SYSCFG     4'h0
`define WDR_OFS_WDTCTL     4'h4
`define WDR_OFS_WDTCNT     4'h8
`define WDR_OFS_STATUS     4'hC

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define WDR_CFG_RDY_EN     0
`define WDR_CFG_RDY_POL    1
`define WDR_CFG_PD_EXTONLY 2
`define WDR_CFG_BIDIR      3
`define WDR_CTL_PRESCALE   0
`define WDR_CTL_RELOAD_LSB 8
`define WDR_ST_WDT_CAUSE   0
`define WDR_ST_SW_CAUSE    1
`define WDR_ST_WARM_CAUSE  2
`define WDR_ST_REFUSED     3
`define WDR_ST_WDT_EN      4
`define WDR_ST_INIT_DONE   5
`define WDR_ST_PMODE_LSB   6

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define WDR_RST_RELOAD     8'h00
`define WDR_RST_CNT        16'h0000
`define WDR_DIV_SLOW       128
`define WDR_DIV_FAST       2
`define WDR_SEQ_TCL        1024
`define WDR_TCL_PER_CYC    2
`define WDR_TRANS_CYC      4
`define WDR_REF_MHZ        50
`define WDR_T_FF_DIV2_NS   10240
`define WDR_OVF_FF_DIV2_CYC ((`WDR_T_FF_DIV2_NS * `WDR_REF_MHZ) / 1000)

`endif

// ### wdr_pkg.sv
package wdr_pkg;

  typedef enum logic [2:0] {
    S_RUN,
    S_HOLD,
    S_WAITBUS,
    S_TRANS,
    S_SEQ,
    S_EXT
  } wdr_seq_t;

  typedef enum logic [1:0] {
    PM_RUN,
    PM_IDLE,
    PM_PD
  } wdr_pmode_t;

endpackage : wdr_pkg

// ### wdr_wdt_if.sv
`timescale 1ns/1ps
interface wdr_wdt_if;
  logic        service;
  logic        run;
  logic        clear;
  logic        prescaleSel;
  logic [7:0]  reload;
  logic [15:0] count;
  logic        overflow;

  modport ctl (output service, run, clear, prescaleSel, reload, input count, overflow);
  modport wdt (input service, run, clear, prescaleSel, reload, output count, overflow);
endinterface : wdr_wdt_if

// ### wdr_sync.sv
`timescale 1ns/1ps
module wdr_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pin in, filtered level out
  input  wire logic d,
  output logic      q
);
  logic q1;
  logic q2;
  logic q3;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q1 <= RESET_VAL;
      q2 <= RESET_VAL;
      q3 <= RESET_VAL;
      q  <= RESET_VAL;
    end else begin
      q1 <= d;
      q2 <= q1;
      q3 <= q2;
      if (q2 == q3) begin
        q <= q3;
      end
    end
  end
endmodule : wdr_sync

// ### wdr_wdt.sv
`timescale 1ns/1ps
`include "wdr_consts.svh"
module wdr_wdt (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control and count
  wdr_wdt_if.wdt    wd
);
  logic [6:0] divCnt;
  wire        tick = wd.run & (wd.prescaleSel ? (divCnt == 7'(`WDR_DIV_SLOW - 1))
                                              : (divCnt[0] == 1'b1));

  assign wd.overflow = tick & (wd.count == 16'hFFFF);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt   <= 7'h00;
      wd.count <= `WDR_RST_CNT;
    end else if (wd.clear) begin
      divCnt   <= 7'h00;
      wd.count <= `WDR_RST_CNT;
    end else if (wd.service) begin
      divCnt   <= 7'h00;
      wd.count <= {wd.reload, 8'h00};
    end else if (wd.run) begin
      divCnt <= divCnt + 7'h01;
      if (tick) begin
        wd.count <= wd.count + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_fastRun2;
    ($past(rst_n) && wd.run && !wd.prescaleSel && !wd.service && !wd.clear)[*2];
  endsequence

  a_wdt_reload_load: assert property (
    wd.service && !wd.clear |=> wd.count == {$past(wd.reload), 8'h00})
    else $error("service did not load reload value");

  a_wdt_fast_rate: assert property (
    s_fastRun2 |=> wd.count == $past(wd.count, 2) + 16'h0001)
    else $error("divide by 2 rate wrong");
endmodule : wdr_wdt

// ### wdr_top.sv
`timescale 1ns/1ps
`include "wdr_consts.svh"
module wdr_top #(
  parameter int TRANS_CYC = `WDR_TRANS_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // CPU strobes and levels
  input  wire logic        wdtService,
  input  wire logic        wdtDisable,
  input  wire logic        endOfInitInstruction,
  input  wire logic        softwareResetInstruction,
  input  wire logic        idleReq,
  input  wire logic        powerDownReq,
  input  wire logic        irqPending,
  input  wire logic        bootMode,
  // External bus controller
  input  wire logic        busActive,
  input  wire logic        busWaitDone,
  output logic             busAbort,
  output logic             holdCancel,
  // Pins
  input  wire logic        resetInPinIn,
  output logic             resetInPinOut,
  output logic             resetInPinOe,
  output logic             resetOutPin_n,
  input  wire logic        readyPin,
  input  wire logic        fastIntPin_n,
  output logic             ioHighZ,
  // System control
  output logic             sysReset,
  output logic             cpuHalt,
  output logic             periphHalt,
  output logic             sleepRefused
);
  import wdr_pkg::*;

  localparam int SEQ_CYC = `WDR_SEQ_TCL / `WDR_TCL_PER_CYC;
  localparam logic [9:0] SEQ_LAST   = 10'(SEQ_CYC - 1);
  localparam logic [3:0] TRANS_LAST = 4'(TRANS_CYC - 1);
  // Overflow span at the reference clock for reload FF, divide by 2
  localparam int OVF_MIN_CYC = `WDR_OVF_FF_DIV2_CYC;

  // --------------------------------------------------------------------------
  // Reset release synchroniser and pin synchronisers
  // --------------------------------------------------------------------------
  logic relA;
  logic relB;
  logic rstInSync;
  logic readySync;
  logic fastIntSync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      relA <= 1'b0;
      relB <= 1'b0;
    end else begin
      relA <= 1'b1;
      relB <= relA;
    end
  end

  wdr_sync #(.RESET_VAL(1'b1)) u_syncRstIn (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (resetInPinIn),
    .q     (rstInSync)
  );

  wdr_sync #(.RESET_VAL(1'b1)) u_syncReady (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (readyPin),
    .q     (readySync)
  );

  wdr_sync #(.RESET_VAL(1'b1)) u_syncFast (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (fastIntPin_n),
    .q     (fastIntSync_n)
  );

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  logic       readyEnable;
  logic       readyPolarity;
  logic       pdExtOnly;
  logic       bidirResetEnable;
  logic [7:0] watchdogReloadValue;
  logic       watchdogPrescaleSelect;
  logic       wdtEnabled;
  logic       initDone;
  logic       wdtCause;
  logic       swCause;
  logic       warmCause;
  logic       refusedFlag;
  logic       ack;

  wdr_seq_t   state;
  wdr_seq_t   next_state;
  wdr_pmode_t pmode;
  wdr_pmode_t next_pmode;
  logic [9:0] seqCnt;
  logic [3:0] transCnt;
  logic       sleepPend;
  logic       sleepPd;
  logic       readySeen;
  logic       busActiveQ;
  // Cause of the running sequence; the sticky status flags cannot tell
  logic       seqFromWdt;

  wdr_wdt_if wd ();

  wdr_wdt u_wdt (
    .clk   (clk),
    .rst_n (rst_n),
    .wd    (wd)
  );

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  wire reqValid   = avs_read | avs_write;
  wire wrEn       = avs_write & ack;
  wire selCfg     = avs_address == `WDR_OFS_SYSCFG;
  wire selCtl     = avs_address == `WDR_OFS_WDTCTL;
  wire selCnt     = avs_address == `WDR_OFS_WDTCNT;
  wire selSt      = avs_address == `WDR_OFS_STATUS;
  wire wrCfg      = wrEn & selCfg & avs_byteenable[0];
  wire wrCtlLo    = wrEn & selCtl & avs_byteenable[0];
  wire wrCtlHi    = wrEn & selCtl & avs_byteenable[1];
  wire wrSt       = wrEn & selSt & avs_byteenable[0];

  wire inRun      = state == S_RUN;
  wire seqEnd     = (state == S_SEQ) && (seqCnt == SEQ_LAST);
  wire transEnd   = (state == S_TRANS) && (transCnt == TRANS_LAST);
  wire readyAct   = readySync == readyPolarity;
  wire warmReq    = inRun & ~rstInSync;
  wire swReq      = inRun & rstInSync & softwareResetInstruction;
  wire wdtReq     = inRun & rstInSync & ~softwareResetInstruction
                    & wd.overflow & ~bootMode;
  wire wdtAbort   = (state == S_WAITBUS) & busActive & readyEnable
                    & busWaitDone & ~readyAct;
  wire wdtBusGo   = ~busActive | wdtAbort;
  wire sleepDec   = sleepPend & ~busActive & inRun;
  wire refuse     = sleepDec & readyEnable & ~readySeen;
  wire sleepGo    = sleepDec & ~refuse;
  wire fastInt    = ~fastIntSync_n;
  wire pdWake     = fastInt | (~pdExtOnly & irqPending);

  wire [31:0] cfgWord = {28'h0, bidirResetEnable, pdExtOnly, readyPolarity, readyEnable};
  wire [31:0] ctlWord = {16'h0, watchdogReloadValue, 7'h00, watchdogPrescaleSelect};
  wire [31:0] cntWord = {16'h0, wd.count};
  wire [31:0] stWord  = {24'h0, 2'(pmode), initDone, wdtEnabled, refusedFlag,
                         warmCause, swCause, wdtCause};
  wire [31:0] rdMux   = selCfg ? cfgWord :
                        selCtl ? ctlWord :
                        selCnt ? cntWord :
                        selSt  ? stWord  : 32'h0000_0000;

  assign avs_waitrequest = reqValid & ~ack;

  // --------------------------------------------------------------------------
  // Watchdog control
  // --------------------------------------------------------------------------
  assign wd.service     = wdtService & inRun;
  assign wd.run         = wdtEnabled & inRun & (pmode != PM_PD);
  assign wd.clear       = seqEnd;
  assign wd.prescaleSel = watchdogPrescaleSelect;
  assign wd.reload      = watchdogReloadValue;

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign sysReset      = ~relB | ~inRun;
  assign ioHighZ       = ~resetInPinIn | sysReset;
  assign resetOutPin_n = resetInPinIn & ~sysReset;
  assign resetInPinOe  = (state == S_SEQ) & bidirResetEnable;
  assign resetInPinOut = 1'b0;
  assign holdCancel    = state == S_TRANS;
  assign busAbort      = wdtAbort | ((state == S_TRANS) & ~seqFromWdt);
  assign cpuHalt       = pmode != PM_RUN;
  assign periphHalt    = pmode == PM_PD;
  assign sleepRefused  = refuse;

  // --------------------------------------------------------------------------
  // Reset sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      S_RUN: begin
        if (warmReq) begin
          next_state = S_HOLD;
        end else if (swReq) begin
          next_state = S_TRANS;
        end else if (wdtReq) begin
          next_state = S_WAITBUS;
        end
      end
      S_HOLD: begin
        if (rstInSync) begin
          next_state = S_TRANS;
        end
      end
      S_WAITBUS: begin
        if (wdtBusGo) begin
          next_state = S_TRANS;
        end
      end
      S_TRANS: begin
        if (transEnd) begin
          next_state = S_SEQ;
        end
      end
      S_SEQ: begin
        if (seqEnd) begin
          next_state = S_EXT;
        end
      end
      S_EXT: begin
        if (rstInSync) begin
          next_state = S_RUN;
        end
      end
      default: next_state = S_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= S_RUN;
      seqCnt   <= 10'h000;
      transCnt   <= 4'h0;
      seqFromWdt <= 1'b0;
    end else begin
      if (wdtReq || warmReq || swReq) begin
        seqFromWdt <= wdtReq;
      end
      state    <= next_state;
      seqCnt   <= (state == S_SEQ) ? seqCnt + 10'h001 : 10'h000;
      transCnt <= (state == S_TRANS) ? transCnt + 4'h1 : 4'h0;
    end
  end

  // --------------------------------------------------------------------------
  // Power reduction
  // --------------------------------------------------------------------------
  always_comb begin
    next_pmode = pmode;
    case (pmode)
      PM_RUN: begin
        if (sleepGo) begin
          next_pmode = sleepPd ? PM_PD : PM_IDLE;
        end
      end
      PM_IDLE: begin
        if (irqPending) begin
          next_pmode = PM_RUN;
        end
      end
      PM_PD: begin
        if (pdWake) begin
          next_pmode = PM_RUN;
        end
      end
      default: next_pmode = PM_RUN;
    endcase
    if (!inRun) begin
      next_pmode = PM_RUN;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pmode      <= PM_RUN;
      sleepPend  <= 1'b0;
      sleepPd    <= 1'b0;
      readySeen  <= 1'b1;
      busActiveQ <= 1'b0;
    end else begin
      pmode      <= next_pmode;
      busActiveQ <= busActive;
      if (busActive & ~busActiveQ) begin
        readySeen <= readyAct;
      end else if (busActive & readyAct) begin
        readySeen <= 1'b1;
      end
      if (!inRun || sleepDec) begin
        sleepPend <= 1'b0;
      end else if ((pmode == PM_RUN) && !sleepPend && (idleReq || powerDownReq)) begin
        sleepPend <= 1'b1;
        sleepPd   <= powerDownReq;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack          <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack <= reqValid & ~ack;
      if (avs_read & ~ack) begin
        avs_readdata <= rdMux;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readyEnable            <= 1'b0;
      readyPolarity          <= 1'b0;
      pdExtOnly              <= 1'b0;
      bidirResetEnable       <= 1'b0;
      watchdogReloadValue    <= `WDR_RST_RELOAD;
      watchdogPrescaleSelect <= 1'b0;
    end else if (seqEnd) begin
      bidirResetEnable       <= 1'b0;
      watchdogReloadValue    <= `WDR_RST_RELOAD;
      watchdogPrescaleSelect <= 1'b0;
    end else begin
      if (wrCfg) begin
        readyEnable      <= avs_writedata[`WDR_CFG_RDY_EN];
        readyPolarity    <= avs_writedata[`WDR_CFG_RDY_POL];
        pdExtOnly        <= avs_writedata[`WDR_CFG_PD_EXTONLY];
        bidirResetEnable <= avs_writedata[`WDR_CFG_BIDIR];
      end
      if (wrCtlLo) begin
        watchdogPrescaleSelect <= avs_writedata[`WDR_CTL_PRESCALE];
      end
      if (wrCtlHi) begin
        watchdogReloadValue <= avs_writedata[`WDR_CTL_RELOAD_LSB +: 8];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdtEnabled <= 1'b1;
      initDone   <= 1'b0;
    end else if (seqEnd) begin
      wdtEnabled <= 1'b1;
      initDone   <= 1'b0;
    end else begin
      if (endOfInitInstruction) begin
        initDone <= 1'b1;
      end
      if (wdtDisable && !initDone && !endOfInitInstruction) begin
        wdtEnabled <= 1'b0;
      end
    end
  end

  // Cause and refusal flags: a hardware set wins over a write-one clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdtCause    <= 1'b0;
      swCause     <= 1'b0;
      warmCause   <= 1'b0;
      refusedFlag <= 1'b0;
    end else begin
      wdtCause    <= wdtReq  | (wdtCause  & ~(wrSt & avs_writedata[`WDR_ST_WDT_CAUSE]));
      swCause     <= swReq   | (swCause   & ~(wrSt & avs_writedata[`WDR_ST_SW_CAUSE]));
      warmCause   <= warmReq | (warmCause & ~(wrSt & avs_writedata[`WDR_ST_WARM_CAUSE]));
      refusedFlag <= refuse  | (refusedFlag & ~(wrSt & avs_writedata[`WDR_ST_REFUSED]));
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_transStart;
    state != S_TRANS ##1 state == S_TRANS;
  endsequence

  sequence s_seqLastCycle;
    state == S_SEQ && seqCnt == SEQ_LAST;
  endsequence

  a_init_lock: assert property (
    initDone && wdtEnabled && !seqEnd |=> wdtEnabled)
    else $error("watchdog disabled after end of init");

  a_wdt_reset_go: assert property (
    wdtReq |=> state == S_WAITBUS && !resetOutPin_n && sysReset)
    else $error("overflow did not start reset");

  a_boot_block: assert property (
    bootMode && inRun && rstInSync && !softwareResetInstruction |=> state != S_WAITBUS)
    else $error("watchdog reset in bootstrap mode");

  a_warm_hiz: assert property (
    !resetInPinIn |-> ioHighZ && !resetOutPin_n)
    else $error("reset-in low without float");

  a_trans_hold: assert property (
    s_transStart |-> holdCancel [*4] ##1 state == S_SEQ)
    else $error("transition period wrong");

  a_seq_step: assert property (
    state == S_SEQ && seqCnt != SEQ_LAST |=> state == S_SEQ && seqCnt == $past(seqCnt) + 10'h001)
    else $error("reset sequence cut short");

  a_seq_exit: assert property (
    s_seqLastCycle |=> state == S_EXT && !bidirResetEnable && wdtEnabled)
    else $error("sequence end wrong");

  a_bidir_drive: assert property (
    state == S_SEQ && bidirResetEnable |-> resetInPinOe && !resetInPinOut)
    else $error("reset-in not driven");

  a_ext_hold: assert property (
    state == S_EXT && !rstInSync |=> state == S_EXT && sysReset)
    else $error("reset not prolonged");

  a_sw_start: assert property (
    swReq |=> state == S_TRANS)
    else $error("software reset ignored");

  a_wdt_abort: assert property (
    wdtAbort |-> busAbort ##1 state == S_TRANS)
    else $error("bus cycle not aborted");

  a_sleep_refuse: assert property (
    refuse && pmode == PM_RUN |=> pmode == PM_RUN && refusedFlag)
    else $error("sleep entered without ready");

  a_pd_halt: assert property (
    pmode == PM_PD && !pdWake && inRun |=> pmode == PM_PD && cpuHalt && periphHalt)
    else $error("power-down left early");
endmodule : wdr_top

// ### wdr_cpu_ext_model.sv
`timescale 1ns/1ps
module wdr_cpu_ext_model (
  // Device pin drive
  input  wire logic resetInPinOe,
  input  wire logic resetInPinOut,
  // External reset circuit pulls low
  input  wire logic extLow,
  // Resolved pulled-up pin
  output logic      resetInPinIn
);
  // Open-drain line with pull-up: either party can hold it low
  assign resetInPinIn = ~((resetInPinOe & ~resetInPinOut) | extLow);
endmodule : wdr_cpu_ext_model

// ### wdr_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module wdr_top_tb;
  logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, extLow;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [5:0]  stb;
  logic        readyPin, fastIntPin_n, busWaitDone, busAbort, holdCancel, sleepRefused;
  logic        irqPending, bootMode, busActive, resetInPinIn, resetInPinOut, resetInPinOe;
  logic        resetOutPin_n, ioHighZ, sysReset, cpuHalt, periphHalt;
  int          mismatches, comparisons, cyc, n, t0, e2, exp, cfgModel;
  logic [7:0]  lfsr = 8'h3D;

  wdr_top uut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .wdtService(stb[0]),
    .wdtDisable(stb[1]), .endOfInitInstruction(stb[2]), .softwareResetInstruction(stb[3]),
    .idleReq(stb[4]), .powerDownReq(stb[5]), .irqPending, .bootMode, .busActive,
    .busWaitDone, .busAbort, .holdCancel, .resetInPinIn, .resetInPinOut,
    .resetInPinOe, .resetOutPin_n, .readyPin, .fastIntPin_n, .ioHighZ,
    .sysReset, .cpuHalt, .periphHalt, .sleepRefused);
  wdr_cpu_ext_model ext (.resetInPinOe, .resetInPinOut, .extLow, .resetInPinIn);

  // ---------------------------------------------------------------------------
  // Clock, timeout and helpers
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      end_sim();
    end
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (w && a == 4'h0) cfgModel = d & 32'hF;
    if (!w && a == 4'h0) `CHK(rd, cfgModel)
  endtask : bus

  task automatic pulse(input int i);
    @(posedge clk);
    stb[i] <= 1'b1;
    @(posedge clk);
    stb <= '0;
  endtask : pulse

  task automatic wait_run();
    n = 0;
    while (sysReset !== 1'b0) begin
      @(negedge clk);
      n++;
    end
    cfgModel = cfgModel & 32'h7;
  endtask : wait_run

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {stb, irqPending, bootMode, busActive, extLow, busWaitDone} = '0;
    {readyPin, fastIntPin_n} = 2'b11;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wait_run();
    bus(0, 4'h0, 0);
    `CHK(rd, 32'h0)
    bus(0, 4'hC, 0);
    `CHK(rd, 32'h10)
    bus(0, 4'h2, 0);
    `CHK(rd, 32'h0)
    exp = rnd() & 7;
    bus(1, 4'h0, exp);
    bus(0, 4'h0, 0);
    `CHK(rd, exp)
    bus(1, 4'h0, 0);
    pulse(2);
    pulse(1);
    bus(0, 4'hC, 0);
    `CHK(rd[5:4], 2'b11)
    $display("register and lock test done");
    exp = 8'hF0 | (rnd() & 8'h0F);
    e2 = (256 - exp) * 512;
    bus(1, 4'h4, exp << 8);
    pulse(0);
    t0 = cyc;
    bus(0, 4'h8, 0);
    `CHK(rd[15:8], exp[7:0])
    while (sysReset !== 1'b1) @(negedge clk);
    `CHK((cyc - t0 >= e2 - 4) && (cyc - t0 <= e2 + 4), 1'b1)
    `CHK(resetOutPin_n, 1'b0)
    wait_run();
    bus(0, 4'hC, 0);
    `CHK(rd[0], 1'b1)
    pulse(1);
    bus(0, 4'hC, 0);
    `CHK(rd[4], 1'b0)
    $display("overflow test done");
    bus(1, 4'h0, 32'h8);
    pulse(3);
    n = 0;
    e2 = 0;
    t0 = 0;
    repeat (700) begin
      @(negedge clk);
      n += resetInPinOe;
      e2 += busAbort;
      t0 += holdCancel;
    end
    `CHK(n, 512)
    `CHK(e2, 4)
    `CHK(t0, 4)
    wait_run();
    bus(0, 4'h0, 0);
    `CHK(rd[3], 1'b0)
    bus(0, 4'hC, 0);
    `CHK({rd[4], rd[1]}, 2'b11)
    $display("software reset test done");
    @(posedge clk);
    extLow <= 1'b1;
    #1;
    `CHK({ioHighZ, resetOutPin_n}, 2'b10)
    repeat (20) @(posedge clk);
    extLow <= 1'b0;
    wait_run();
    `CHK((n >= 516) && (n <= 530), 1'b1)
    $display("warm reset test done");
    pulse(4);
    repeat (3) @(negedge clk);
    `CHK({cpuHalt, periphHalt}, 2'b10)
    @(posedge clk);
    irqPending <= 1'b1;
    repeat (3) @(negedge clk);
    `CHK(cpuHalt, 1'b0)
    @(posedge clk);
    irqPending <= 1'b0;
    $display("idle test done");
    bus(1, 4'h0, 32'h4);
    pulse(5);
    irqPending <= 1'b1;
    repeat (6) @(negedge clk);
    `CHK({cpuHalt, periphHalt}, 2'b11)
    @(posedge clk);
    fastIntPin_n <= 1'b0;
    repeat (6) @(negedge clk);
    `CHK({cpuHalt, periphHalt}, 2'b00)
    @(posedge clk);
    {fastIntPin_n, irqPending} <= 2'b10;
    $display("power-down test done");
    bus(1, 4'h0, 32'h1);
    busActive <= 1'b1;
    repeat (3) @(posedge clk);
    busActive <= 1'b0;
    pulse(4);
    @(negedge clk);
    `CHK(sleepRefused, 1'b1)
    repeat (3) @(negedge clk);
    bus(0, 4'hC, 0);
    `CHK({rd[3], cpuHalt}, 2'b10)
    $display("sleep refusal test done");
    bus(1, 4'h4, 32'hFF00);
    busActive <= 1'b1;
    pulse(0);
    while (sysReset !== 1'b1) @(negedge clk);
    repeat (8) @(negedge clk);
    `CHK({sysReset, holdCancel}, 2'b10)
    @(posedge clk);
    busWaitDone <= 1'b1;
    @(negedge clk);
    `CHK(busAbort, 1'b1)
    @(posedge clk);
    busWaitDone <= 1'b0;
    busActive   <= 1'b0;
    wait_run();
    $display("watchdog abort test done");
    bootMode <= 1'b1;
    bus(1, 4'h4, 32'hFF00);
    pulse(0);
    repeat (700) @(negedge clk);
    `CHK(sysReset, 1'b0)
    $display("boot mode test done");
    end_sim();
  end
endmodule : wdr_top_tb
